// ==== pkg/hic_pkg.sv ====
package hic_pkg;
   localparam int         BYTE_W      = 8;
   localparam int         FIFO_DEPTH  = 12;
   localparam int         FIFO_AW     = 4;
   localparam int         CNT_W       = 16;
   localparam int         LEG_CNT_W   = 15;
   localparam int         ADDR_W      = 5;
   localparam int         SRST_BIT    = 2;
   // sub-CPU write offsets
   localparam logic [4:0] W_STAT_OUT  = 5'h00;
   localparam logic [4:0] W_CONTROL   = 5'h01;
   localparam logic [4:0] W_CNT_LO    = 5'h02;
   localparam logic [4:0] W_CNT_HI    = 5'h03;
   localparam logic [4:0] W_TRIGGER   = 5'h04;
   localparam logic [4:0] W_ACK       = 5'h05;
   // sub-CPU read offsets
   localparam logic [4:0] R_CMD_IN    = 5'h00;
   localparam logic [4:0] R_STATUS    = 5'h01;
   localparam logic [4:0] R_CNT_LO    = 5'h02;
   localparam logic [4:0] R_CNT_HI    = 5'h03;
   localparam logic [4:0] R_SECTOR    = 5'h0f;
   localparam logic [4:0] R_SUBCODE   = 5'h13;
   localparam logic [4:0] R_PKT_CMD   = 5'h1a;
   localparam logic [4:0] R_DEVCTL    = 5'h1c;
   localparam logic [7:0] EMPTY_READ  = 8'hff;
   localparam logic [7:0] DIAG_CMD    = 8'h90;
   localparam logic [7:0] ZERO_BYTE   = 8'h00;
   localparam logic [9:0] PIN_IDLE    = 10'h3ff;
   localparam logic [15:0] CNT_RESET  = 16'h0000;
   localparam logic [15:0] CNT_STEP   = 16'h0001;

   typedef struct packed {
      logic cmd_irq_mask;
      logic data_end_irq_mask;
      logic sector_irq_mask;
      logic command_break_disable;
      logic data_wait_disable;
      logic status_wait_disable;
      logic data_output_enable;
      logic status_output_enable;
   } hic_ctrl_t;

   typedef struct packed {
      logic command_flag;
      logic data_end_flag;
      logic sector_ready_flag;
      logic subcode_ready_flag;
      logic data_xfer_busy;
      logic reset_or_status_busy;
      logic data_ready_line;
      logic status_ready_line;
   } hic_stat_t;
endpackage

// ==== verilog/hic_sync.sv ====
`timescale 1ns/10ps
module hic_sync #(
   parameter int         W   = 10,
   parameter logic [9:0] RST = hic_pkg::PIN_IDLE
) (
   // clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   // async level in, synced level out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r   <= RST[W-1:0];
         sync_out <= RST[W-1:0];
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

// ==== verilog/hic_fifo.sv ====
`timescale 1ns/10ps
module hic_fifo #(
   parameter int W  = hic_pkg::BYTE_W,
   parameter int D  = hic_pkg::FIFO_DEPTH,
   parameter int AW = hic_pkg::FIFO_AW
) (
   // clock and reset
   input  wire logic          clk_in,
   input  wire logic          rst_n_in,
   // control
   input  wire logic          push_in,
   input  wire logic          pop_in,
   input  wire logic          flush_in,
   input  wire logic [W-1:0]  data_in,
   // state
   output logic      [W-1:0]  head_out,
   output logic               empty_out,
   output logic               full_out,
   output logic      [AW:0]   count_out
);
   localparam logic [AW-1:0] LAST = AW'(D - 1);
   localparam logic [AW:0]   FULL = (AW + 1)'(D);

   logic [W-1:0]  mem_r [D];
   logic [AW-1:0] rd_r;
   logic [AW-1:0] wr_r;
   wire           do_push = push_in && !full_out && !flush_in;
   wire           do_pop  = pop_in && !empty_out && !flush_in;

   assign head_out  = mem_r[rd_r];
   assign empty_out = (count_out == '0);
   assign full_out  = (count_out == FULL);

   always_ff @(posedge clk_in) begin
      if (do_push) begin
         mem_r[wr_r] <= data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_r      <= '0;
         wr_r      <= '0;
         count_out <= '0;
      end else if (flush_in) begin
         rd_r      <= '0;
         wr_r      <= '0;
         count_out <= '0;
      end else begin
         if (do_push) begin
            wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'b1;
         end
         if (do_pop) begin
            rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'b1;
         end
         count_out <= count_out + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      end
   end
endmodule

// ==== verilog/hic_top.sv ====
`timescale 1ns/10ps
// Operation
// - twelve-byte status FIFO, writes start transfer
// - status line falls at once without wait
// - status wait holds line until data high
// - packet bytes only in packet mode, triggered
// - twelve-byte command FIFO, empty reads FFH
// - control cleared at reset, ATAPI uses 7..5
// - bits 7..5 mask interrupts, flags untouched
// - host command write breaks transfers, no flag
// - data waits for status unless bit 3
// - status waits for data unless bit 2
// - bit 1 enables data, zero aborts
// - bit 0 enables status, zero flushes
// - ATAPI status uses bits 7..2 only
// - command flag from command write or FIFO
// - data-end flag set on end, ack clears
// - sector and subcode flags clear on read
// - busy set by trigger, cleared at end
// - soft reset flag, unmaskable interrupt
// - legacy bit 2 shows status transfer busy
// - bits 1..0 mirror lines after host access
// - counter 16 bits, legacy 15 plus flag
// - counter decrements per host read/mem write
module hic_top (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // sub-CPU register port
   input  wire logic [4:0]  addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [7:0]  rdata_out,
   output logic             irq_out,
   // mode
   input  wire logic        atapi_mode_in,
   input  wire logic        packet_mode_in,
   input  wire logic        drive_sel_in,
   // ATAPI task file events
   input  wire logic        ata_cmd_wr_in,
   input  wire logic        ata_devctl_wr_in,
   input  wire logic        ata_pkt_wr_in,
   input  wire logic [7:0]  ata_data_in,
   // legacy host pins
   input  wire logic        host_rd_n_in,
   input  wire logic        host_wr_n_in,
   input  wire logic [7:0]  host_data_in,
   output logic      [7:0]  host_data_out,
   output logic             host_data_oe_out,
   output logic             status_ready_line_n_out,
   output logic             data_ready_line_n_out,
   // buffer memory side
   input  wire logic [7:0]  mem_data_in,
   input  wire logic        mem_byte_wr_in,
   input  wire logic        mem_xfer_done_in,
   // decoder side
   input  wire logic        sector_ready_in,
   input  wire logic        subcode_ready_in,
   input  wire logic [7:0]  sector_status_in,
   input  wire logic [7:0]  subcode_high_in
);
   logic              rst_m_r;
   logic              rst_n;
   logic [9:0]        hsync;
   logic              hrd_d_r;
   logic              hwr_d_r;
   logic              sel_status_r;
   hic_pkg::hic_ctrl_t ctrl_r;
   logic [15:0]       cnt_r;
   logic              data_busy_r;
   logic              status_busy_r;
   logic              cmd_flag_r;
   logic              dte_r;
   logic              sector_r;
   logic              subcode_r;
   logic              srst_r;
   logic [1:0]        mirror_r;
   logic [7:0]        pkt_cmd_r;
   logic [7:0]        devctl_r;
   logic [7:0]        stat_head;
   logic              stat_empty;
   logic [4:0]        stat_count;
   logic [7:0]        cmd_head;
   logic              cmd_empty;
   logic              cmd_full;
   logic [4:0]        cmd_count;

   // reset release through two flops
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_m_r <= 1'b0;
         rst_n   <= 1'b0;
      end else begin
         rst_m_r <= 1'b1;
         rst_n   <= rst_m_r;
      end
   end

   hic_sync #(.W(10), .RST(hic_pkg::PIN_IDLE)) u_pins (
      .clk_in   (clk_in),
      .rst_n_in (rst_n),
      .async_in ({host_rd_n_in, host_wr_n_in, host_data_in}),
      .sync_out (hsync)
   );

   // decode
   wire       legacy     = !atapi_mode_in;
   wire       hrd_n      = hsync[9];
   wire       hwr_n      = hsync[8];
   wire [7:0] hdata      = hsync[7:0];
   wire       h_rd_start = legacy && hrd_d_r && !hrd_n;
   wire       h_rd_done  = legacy && !hrd_d_r && hrd_n;
   wire       h_wr_done  = legacy && !hwr_d_r && hwr_n;
   wire       wr_stat    = wr_in && (addr_in == hic_pkg::W_STAT_OUT);
   wire       wr_ctrl    = wr_in && (addr_in == hic_pkg::W_CONTROL);
   wire       wr_cnt_lo  = wr_in && (addr_in == hic_pkg::W_CNT_LO);
   wire       wr_cnt_hi  = wr_in && (addr_in == hic_pkg::W_CNT_HI);
   wire       wr_trig    = wr_in && (addr_in == hic_pkg::W_TRIGGER);
   wire       wr_ack     = wr_in && (addr_in == hic_pkg::W_ACK);
   wire       rd_cmd     = rd_in && (addr_in == hic_pkg::R_CMD_IN);
   wire       rd_sector  = rd_in && (addr_in == hic_pkg::R_SECTOR);
   wire       rd_subcode = rd_in && (addr_in == hic_pkg::R_SUBCODE);
   wire       rd_pkt_cmd = rd_in && (addr_in == hic_pkg::R_PKT_CMD);
   wire       rd_devctl  = rd_in && (addr_in == hic_pkg::R_DEVCTL);

   // low control bits act only in legacy mode
   wire ctrl_wr_leg = wr_ctrl && legacy;
   wire brk = h_wr_done && !ctrl_r.command_break_disable;
   wire data_abort = ctrl_wr_leg && !wdata_in[1];
   wire stat_flush = (ctrl_wr_leg && !wdata_in[0]) || brk;

   // legacy counts 15 bits, bit 15 is not part of the count
   wire [15:0] cnt_m = legacy ? {1'b0, cnt_r[hic_pkg::LEG_CNT_W-1:0]} : cnt_r;
   wire        cnt_zero = (cnt_m == hic_pkg::CNT_RESET);
   wire        host_data_rd = h_rd_done && !sel_status_r;
   wire dec_en = data_busy_r && !cnt_zero && (host_data_rd || mem_byte_wr_in);
   wire xfer_end = data_busy_r && cnt_zero && !wr_trig && !brk && !data_abort;

   // packet bytes accepted only in ATAPI packet mode and when triggered
   wire pkt_push = atapi_mode_in && packet_mode_in && data_busy_r && ata_pkt_wr_in;
   wire pkt_full_evt = pkt_push && !cmd_full &&
                       (cmd_count == 5'(hic_pkg::FIFO_DEPTH - 1));
   wire cmd_push = h_wr_done || pkt_push;
   wire [7:0] cmd_din = legacy ? hdata : ata_data_in;
   wire stat_push = wr_stat;
   wire stat_pop = h_rd_done && sel_status_r;
   wire stat_pop_last = stat_pop && (stat_count == 5'h01);

   wire cmd_set = atapi_mode_in && ata_cmd_wr_in &&
                  (drive_sel_in || ata_data_in == hic_pkg::DIAG_CMD);
   wire cmd_bit = legacy ? !cmd_empty : cmd_flag_r;
   wire dte_set = xfer_end || pkt_full_evt || (atapi_mode_in && mem_xfer_done_in);
   wire srst_set = atapi_mode_in && ata_devctl_wr_in && ata_data_in[hic_pkg::SRST_BIT];
   wire srst_bit = atapi_mode_in && srst_r;

   // interlocked line levels, low means ready
   wire data_line_nxt = !(legacy && ctrl_r.data_output_enable && data_busy_r && !cnt_zero
                          && (ctrl_r.data_wait_disable || !status_busy_r));
   wire stat_line_nxt = !(legacy && ctrl_r.status_output_enable && !stat_empty
                          && (ctrl_r.status_wait_disable || data_ready_line_n_out));
   wire irq_nxt = (cmd_bit && ctrl_r.cmd_irq_mask) || (dte_r && ctrl_r.data_end_irq_mask)
                  || (sector_r && ctrl_r.sector_irq_mask) || srst_bit;

   hic_pkg::hic_stat_t stat_byte;
   assign stat_byte.command_flag         = cmd_bit;
   assign stat_byte.data_end_flag        = dte_r;
   assign stat_byte.sector_ready_flag    = sector_r;
   assign stat_byte.subcode_ready_flag   = subcode_r;
   assign stat_byte.data_xfer_busy       = data_busy_r;
   assign stat_byte.reset_or_status_busy = atapi_mode_in ? srst_r : status_busy_r;
   assign stat_byte.data_ready_line      = legacy && mirror_r[1];
   assign stat_byte.status_ready_line    = legacy && mirror_r[0];

   wire [7:0] cnt_hi_rd = legacy ? {dte_r, cnt_r[14:8]} : cnt_r[15:8];
   wire [7:0] rdata_nxt =
      (addr_in == hic_pkg::R_CMD_IN)  ? (cmd_empty ? hic_pkg::EMPTY_READ : cmd_head) :
      (addr_in == hic_pkg::R_STATUS)  ? stat_byte :
      (addr_in == hic_pkg::R_CNT_LO)  ? cnt_r[7:0] :
      (addr_in == hic_pkg::R_CNT_HI)  ? cnt_hi_rd :
      (addr_in == hic_pkg::R_SECTOR)  ? sector_status_in :
      (addr_in == hic_pkg::R_SUBCODE) ? subcode_high_in :
      (addr_in == hic_pkg::R_PKT_CMD) ? pkt_cmd_r :
      (addr_in == hic_pkg::R_DEVCTL)  ? devctl_r : hic_pkg::ZERO_BYTE;

   wire [15:0] cnt_nxt = wr_cnt_lo ? {cnt_r[15:8], wdata_in} :
                         wr_cnt_hi ? {wdata_in, cnt_r[7:0]} :
                         dec_en    ? cnt_r - hic_pkg::CNT_STEP : cnt_r;

   hic_fifo u_stat_fifo (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n),
      .push_in   (stat_push),
      .pop_in    (stat_pop),
      .flush_in  (stat_flush),
      .data_in   (wdata_in),
      .head_out  (stat_head),
      .empty_out (stat_empty),
      .full_out  (),
      .count_out (stat_count)
   );

   hic_fifo u_cmd_fifo (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n),
      .push_in   (cmd_push),
      .pop_in    (rd_cmd),
      .flush_in  (1'b0),
      .data_in   (cmd_din),
      .head_out  (cmd_head),
      .empty_out (cmd_empty),
      .full_out  (cmd_full),
      .count_out (cmd_count)
   );

   // control and counter
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= '0;
         cnt_r  <= hic_pkg::CNT_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= hic_pkg::hic_ctrl_t'(wdata_in);
         end
         cnt_r <= cnt_nxt;
      end
   end

   // transfer state; a set wins over a clear in the same cycle
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         data_busy_r   <= 1'b0;
         status_busy_r <= 1'b0;
      end else begin
         data_busy_r   <= (data_busy_r && !(xfer_end || data_abort || brk)) || wr_trig;
         status_busy_r <= (status_busy_r && !(stat_pop_last || stat_flush))
                          || (wr_stat && legacy);
      end
   end

   // event flags
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         cmd_flag_r <= 1'b0;
         dte_r      <= 1'b0;
         sector_r   <= 1'b0;
         subcode_r  <= 1'b0;
         srst_r     <= 1'b0;
      end else begin
         cmd_flag_r <= (cmd_flag_r && !rd_pkt_cmd) || cmd_set;
         dte_r      <= (dte_r && !wr_ack) || dte_set;
         sector_r   <= (sector_r && !rd_sector) || sector_ready_in;
         subcode_r  <= (subcode_r && !rd_subcode) || subcode_ready_in;
         srst_r     <= (srst_r && !rd_devctl) || srst_set;
      end
   end

   // host pin side
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         hrd_d_r                 <= 1'b1;
         hwr_d_r                 <= 1'b1;
         sel_status_r            <= 1'b0;
         mirror_r                <= 2'h3;
         host_data_out           <= hic_pkg::ZERO_BYTE;
         host_data_oe_out        <= 1'b0;
         status_ready_line_n_out <= 1'b1;
         data_ready_line_n_out   <= 1'b1;
      end else begin
         hrd_d_r                 <= hrd_n;
         hwr_d_r                 <= hwr_n;
         host_data_oe_out        <= legacy && !hrd_n;
         status_ready_line_n_out <= stat_line_nxt;
         data_ready_line_n_out   <= data_line_nxt;
         if (h_rd_start) begin
            sel_status_r  <= !status_ready_line_n_out;
            host_data_out <= status_ready_line_n_out ? mem_data_in : stat_head;
         end
         if (h_rd_done || h_wr_done) begin
            mirror_r <= {data_ready_line_n_out, status_ready_line_n_out};
         end
      end
   end

   // register read data and interrupt
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_out <= hic_pkg::ZERO_BYTE;
         irq_out   <= 1'b0;
         pkt_cmd_r <= hic_pkg::ZERO_BYTE;
         devctl_r  <= hic_pkg::ZERO_BYTE;
      end else begin
         rdata_out <= rd_in ? rdata_nxt : hic_pkg::ZERO_BYTE;
         irq_out   <= irq_nxt;
         if (ata_cmd_wr_in) begin
            pkt_cmd_r <= ata_data_in;
         end
         if (ata_devctl_wr_in) begin
            devctl_r <= ata_data_in;
         end
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n);

   a_status_fall: assert property (legacy && ctrl_r.status_output_enable &&
      ctrl_r.status_wait_disable && !stat_empty |=> !status_ready_line_n_out)
      else $error("status line did not fall");
   a_status_hold: assert property (!ctrl_r.status_wait_disable &&
      !data_ready_line_n_out |=> status_ready_line_n_out)
      else $error("status line fell during data");
   a_empty_ff: assert property (rd_cmd && cmd_empty |=>
      rdata_out == hic_pkg::EMPTY_READ) else $error("empty command read not FFH");
   a_atapi_lines: assert property (atapi_mode_in |=>
      data_ready_line_n_out && status_ready_line_n_out) else $error("line active in ATAPI");
   a_irq_masked: assert property (!srst_bit && ctrl_r[7:5] == 3'h0 && !wr_ctrl
      |=> !irq_out) else $error("masked interrupt raised");
   a_break_quiet: assert property (brk && !pkt_push && !mem_xfer_done_in && !wr_trig
      |=> !data_busy_r && !$rose(dte_r)) else $error("command break raised data end");
   a_abort_data: assert property (data_abort && !wr_trig |=> !data_busy_r)
      else $error("data transfer not aborted");
   a_flush_stat: assert property (stat_flush && !wr_stat |=>
      stat_empty && !status_busy_r ##1 status_ready_line_n_out)
      else $error("status FIFO not flushed");
   a_trig_busy: assert property (wr_trig |=> data_busy_r)
      else $error("trigger did not set busy");
   a_srst_irq: assert property (srst_set |=> ##1 irq_out)
      else $error("soft reset interrupt missing");
   a_count_dec: assert property (dec_en && !wr_cnt_lo && !wr_cnt_hi |=>
      cnt_r == $past(cnt_r) - hic_pkg::CNT_STEP) else $error("counter did not decrement");

   c_trigger: cover property (wr_trig ##[1:50] xfer_end);
   c_status_out: cover property (wr_stat ##[1:20] stat_pop_last);
   c_packet: cover property (pkt_full_evt);
   c_break: cover property (brk && data_busy_r);
endmodule

// ==== verification/hic_host_model.sv ====
`timescale 1ns/10ps
module hic_host_model (
   // clock
   input  wire logic       clk_in,
   // device pins seen by the host
   input  wire logic [7:0] dev_data_in,
   input  wire logic       dev_oe_in,
   // host strobes and data
   output logic            rd_n_out,
   output logic            wr_n_out,
   output logic [7:0]      data_out
);
   initial begin
      rd_n_out = 1'h1;
      wr_n_out = 1'h1;
      data_out = 8'h00;
   end

   // hold is the strobe length in clocks; device syncs pins, so keep it >= 4
   task automatic host_read(input int hold, output logic [7:0] d, output logic oe);
      rd_n_out <= 1'h0;
      repeat (hold) @(posedge clk_in);
      d = dev_data_in;
      oe = dev_oe_in;
      rd_n_out <= 1'h1;
      repeat (6) @(posedge clk_in);
   endtask

   task automatic host_write(input int hold, input logic [7:0] d);
      data_out <= d;
      wr_n_out <= 1'h0;
      repeat (hold) @(posedge clk_in);
      wr_n_out <= 1'h1;
      repeat (4) @(posedge clk_in);
      // released bus: show a changed value, never the stale byte
      data_out <= ~d;
      repeat (2) @(posedge clk_in);
   endtask
endmodule

// ==== verification/hic_top_tb_top.sv ====
`timescale 1ns/10ps
module hic_top_tb_top;
   logic       clk_in = 1'h0;
   logic       rst_n_in = 1'h0;
   logic [4:0] addr_in = 5'h00;
   logic [7:0] wdata_in = 8'h00;
   logic       wr_in = 1'h0;
   logic       rd_in = 1'h0;
   logic       atapi_mode_in = 1'h0;
   logic       packet_mode_in = 1'h0;
   logic       ata_pkt_wr_in = 1'h0;
   logic       drive_sel_in = 1'h0;
   logic       ata_cmd_wr_in = 1'h0;
   logic       ata_devctl_wr_in = 1'h0;
   logic [7:0] ata_data_in = 8'h00;
   logic [7:0] mem_data_in = 8'h00;
   logic       sector_ready_in = 1'h0;
   logic       subcode_ready_in = 1'h0;
   logic [7:0] sector_status_in = 8'h00;
   logic [7:0] subcode_high_in = 8'h00;
   logic       host_rd_n_in, host_wr_n_in, host_data_oe_out, irq_out, oe;
   logic       status_ready_line_n_out, data_ready_line_n_out;
   logic [7:0] host_data_in, host_data_out, rdata_out, b, m, d;
   logic [7:0] eq[$], mq[$], v[13];
   logic       rs = 1'h0;
   int         fails = 0, total_checks = 0;

   hic_top uut (
      .clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out,
      .atapi_mode_in, .packet_mode_in, .drive_sel_in, .ata_cmd_wr_in,
      .ata_devctl_wr_in, .ata_pkt_wr_in, .ata_data_in, .host_rd_n_in,
      .host_wr_n_in, .host_data_in, .host_data_out, .host_data_oe_out,
      .status_ready_line_n_out, .data_ready_line_n_out, .mem_data_in,
      .mem_byte_wr_in(1'h0), .mem_xfer_done_in(1'h0), .sector_ready_in,
      .subcode_ready_in, .sector_status_in, .subcode_high_in
   );

   hic_host_model host (
      .clk_in, .dev_data_in(host_data_out), .dev_oe_in(host_data_oe_out),
      .rd_n_out(host_rd_n_in), .wr_n_out(host_wr_n_in), .data_out(host_data_in)
   );

   always #50 clk_in = ~clk_in;

   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] e);
      total_checks++;
      if (seen !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, seen);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] x);
      addr_in <= a;
      wdata_in <= x;
      wr_in <= 1'h1;
      @(posedge clk_in);
      wr_in <= 1'h0;
      @(posedge clk_in);
   endtask

   // read data is compared by the watcher below, oldest note first
   task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] k);
      addr_in <= a;
      rd_in <= 1'h1;
      eq.push_back(e & k);
      mq.push_back(k);
      @(posedge clk_in);
      rd_in <= 1'h0;
      @(posedge clk_in);
   endtask

   always @(posedge clk_in) begin
      if (rs)
         chk("rdata", rdata_out & mq.pop_front(), eq.pop_front());
      rs <= rd_in;
   end

   function automatic logic pin(input int s);
      return s == 0 ? status_ready_line_n_out : s == 1 ? data_ready_line_n_out : irq_out;
   endfunction

   // 0 status line, 1 data line, 2 interrupt
   task automatic wpin(input int s, input logic l);
      int i;
      i = 0;
      #1;
      while (pin(s) !== l && i < 30) begin
         @(posedge clk_in);
         #1;
         i++;
      end
      chk($sformatf("pin%0d", s), {7'h00, pin(s)}, {7'h00, l});
   endtask

   initial begin
      #3_000_000;
      fails++;
      summarize();
   end

   initial begin
      void'($urandom(19));
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'h1;
      repeat (4) @(posedge clk_in);
      wpin(0, 1'h1);
      wpin(2, 1'h0);
      rd(hic_pkg::R_CMD_IN, 8'hff, 8'hff);
      rd(5'h05, 8'h00, 8'hff);
      // status byte, wait function off
      b = 8'($urandom);
      wr(hic_pkg::W_CONTROL, 8'h05);
      wr(hic_pkg::W_STAT_OUT, b);
      wpin(0, 1'h0);
      rd(hic_pkg::R_STATUS, 8'h04, 8'h04);
      host.host_read(6, d, oe);
      chk("sbyte", d, b);
      chk("oe", {7'h00, oe}, 8'h01);
      wpin(0, 1'h1);
      rd(hic_pkg::R_STATUS, 8'h00, 8'h04);
      rd(hic_pkg::R_STATUS, 8'h02, 8'h03);
      // data transfer of two bytes with a status byte waiting behind it
      m = 8'($urandom);
      mem_data_in <= m;
      wr(hic_pkg::W_CONTROL, 8'h5b);
      wr(hic_pkg::W_CNT_LO, 8'h02);
      wr(hic_pkg::W_CNT_HI, 8'h00);
      wr(hic_pkg::W_TRIGGER, 8'h00);
      wpin(1, 1'h0);
      rd(hic_pkg::R_STATUS, 8'h08, 8'h08);
      wr(hic_pkg::W_STAT_OUT, b);
      repeat (8) @(posedge clk_in);
      wpin(0, 1'h1);
      host.host_read(12, d, oe);
      chk("dbyte", d, m);
      rd(hic_pkg::R_CNT_LO, 8'h01, 8'hff);
      rd(hic_pkg::R_CNT_HI, 8'h00, 8'hff);
      host.host_read(6, d, oe);
      wpin(1, 1'h1);
      wpin(0, 1'h0);
      rd(hic_pkg::R_STATUS, 8'h44, 8'hfc);
      rd(hic_pkg::R_CNT_HI, 8'h80, 8'hff);
      wpin(2, 1'h1);
      wr(hic_pkg::W_ACK, 8'h00);
      wpin(2, 1'h0);
      rd(hic_pkg::R_STATUS, 8'h04, 8'hfc);
      // clearing the status enable flushes what is queued
      wr(hic_pkg::W_STAT_OUT, b);
      wr(hic_pkg::W_CONTROL, 8'h5a);
      wpin(0, 1'h1);
      rd(hic_pkg::R_STATUS, 8'h00, 8'h04);
      wr(hic_pkg::W_CONTROL, 8'h5b);
      repeat (8) @(posedge clk_in);
      wpin(0, 1'h1);
      // abort by clearing the data enable
      wr(hic_pkg::W_CNT_LO, 8'h03);
      wr(hic_pkg::W_TRIGGER, 8'h00);
      wpin(1, 1'h0);
      wr(hic_pkg::W_CONTROL, 8'h59);
      wpin(1, 1'h1);
      rd(hic_pkg::R_STATUS, 8'h00, 8'h08);
      // command break ends data and status transfers
      wr(hic_pkg::W_CONTROL, 8'h4b);
      wr(hic_pkg::W_CNT_LO, 8'h05);
      wr(hic_pkg::W_TRIGGER, 8'h00);
      wpin(1, 1'h0);
      wr(hic_pkg::W_STAT_OUT, b);
      host.host_write(4, m);
      wpin(1, 1'h1);
      wpin(0, 1'h1);
      rd(hic_pkg::R_STATUS, 8'h80, 8'hcc);
      wpin(2, 1'h0);
      rd(hic_pkg::R_CMD_IN, m, 8'hff);
      // command FIFO filled past twelve, then drained
      wr(hic_pkg::W_CONTROL, 8'h90);
      for (int i = 0; i < 13; i++) begin
         v[i] = 8'($urandom);
         host.host_write(i % 2 ? 10 : 4, v[i]);
      end
      wpin(2, 1'h1);
      rd(hic_pkg::R_STATUS, 8'h80, 8'h80);
      for (int i = 0; i < 12; i++)
         rd(hic_pkg::R_CMD_IN, v[i], 8'hff);
      rd(hic_pkg::R_CMD_IN, 8'hff, 8'hff);
      rd(hic_pkg::R_STATUS, 8'h00, 8'h80);
      wpin(2, 1'h0);
      // ATAPI events
      atapi_mode_in <= 1'h1;
      wr(hic_pkg::W_CONTROL, 8'h00);
      ata_data_in <= 8'h04;
      ata_devctl_wr_in <= 1'h1;
      @(posedge clk_in);
      ata_devctl_wr_in <= 1'h0;
      wpin(2, 1'h1);
      rd(hic_pkg::R_STATUS, 8'h04, 8'hff);
      rd(hic_pkg::R_DEVCTL, 8'h04, 8'hff);
      rd(hic_pkg::R_STATUS, 8'h00, 8'hff);
      for (int i = 0; i < 2; i++) begin
         ata_data_in <= i ? hic_pkg::DIAG_CMD : 8'ha0;
         ata_cmd_wr_in <= 1'h1;
         @(posedge clk_in);
         ata_cmd_wr_in <= 1'h0;
         @(posedge clk_in);
         rd(hic_pkg::R_STATUS, i ? 8'h80 : 8'h00, 8'h80);
      end
      rd(hic_pkg::R_PKT_CMD, hic_pkg::DIAG_CMD, 8'hff);
      rd(hic_pkg::R_STATUS, 8'h00, 8'h80);
      b = 8'($urandom);
      sector_status_in <= b;
      subcode_high_in <= ~b;
      sector_ready_in <= 1'h1;
      subcode_ready_in <= 1'h1;
      @(posedge clk_in);
      sector_ready_in <= 1'h0;
      subcode_ready_in <= 1'h0;
      repeat (4) @(posedge clk_in);
      wpin(2, 1'h0);
      rd(hic_pkg::R_STATUS, 8'h30, 8'hff);
      wr(hic_pkg::W_CONTROL, 8'h20);
      wpin(2, 1'h1);
      rd(hic_pkg::R_SECTOR, b, 8'hff);
      rd(hic_pkg::R_SUBCODE, ~b, 8'hff);
      rd(hic_pkg::R_STATUS, 8'h00, 8'hff);
      wpin(2, 1'h0);
      wr(hic_pkg::W_CNT_HI, 8'h80);
      rd(hic_pkg::R_CNT_HI, 8'h80, 8'hff);
      // packet bytes count only once a transfer is started
      packet_mode_in <= 1'h1;
      for (int i = 0; i < 13; i++) begin
         if (i == 1)
            wr(hic_pkg::W_TRIGGER, 8'h00);
         ata_data_in <= v[i];
         ata_pkt_wr_in <= 1'h1;
         @(posedge clk_in);
         ata_pkt_wr_in <= 1'h0;
         @(posedge clk_in);
      end
      rd(hic_pkg::R_STATUS, 8'h48, 8'hff);
      for (int i = 1; i < 13; i++)
         rd(hic_pkg::R_CMD_IN, v[i], 8'hff);
      repeat (4) @(posedge clk_in);
      summarize();
   end
endmodule
